// file: rtl/lrc_top.sv
// lrc_top: packet receiver for the execute and restart loader commands
// assumes: rx bytes arrive as one-cycle strobes, tx ready accepts a byte per strobe
// assumes: sys_reset_o is wired into the device reset outside this block
// assumes: the host waits for the response before it sends the next packet
// assumes: only a good packet with another opcode is handed on, with its opcode
// What this block does
// - execute opcode 0x22 jumps to the 32-bit address in the packet.
// - acknowledge byte goes out before the jump is started.
// - restart opcode 0x25, size 3, checksum equals opcode; device is reset.
// - acknowledge byte goes out before the restart reset is issued.
// - restart is full reset reloading stack pointer; execute is not.
// - acknowledge is 0xCC, not-acknowledge 0x33; leading zero bytes are skipped.
// - checksum equals sum of data bytes, excluding size and checksum.
`timescale 1ns/100ps
module lrc_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // received bytes
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // transmitted response bytes
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // actions
  output logic run_o,
  output logic [31:0] run_addr_o,
  output logic sys_reset_o,
  // packet seen for another opcode, handed on
  output logic other_cmd_o,
  output logic [7:0] other_op_o
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CSUM = 6'b000010,
    ST_DATA = 6'b000100,
    ST_RESP = 6'b001000,
    ST_ACT = 6'b010000,
    ST_RST = 6'b100000
  } lrc_state_type;

  typedef struct packed {
    lrc_state_type state;
    // packet being received
    logic [7:0] size;
    logic [7:0] csum;
    logic [7:0] sum;
    logic [7:0] opcode;
    logic [7:0] count;
    logic [31:0] addr;
    logic good;
    // response byte offered to the host
    logic tx_valid;
    logic [7:0] tx_data;
    // action requests
    logic run;
    logic [31:0] run_addr;
    logic sys_reset;
    logic [3:0] rst_cnt;
    logic other_cmd;
    logic [7:0] other_op;
  } lrc_regs_type;

  lrc_regs_type r_reg;
  lrc_regs_type r_next;
  logic [7:0] mem_rdata;
  logic mem_we;

  // checks size against opcode; unknown opcodes need at least the minimum size
  function automatic logic size_ok(input logic [7:0] op, input logic [7:0] sz);
    if (op == lrc_pkg::OP_RUN) begin
      size_ok = (sz == lrc_pkg::SIZE_RUN);
    end else if (op == lrc_pkg::OP_RESTART) begin
      size_ok = (sz == lrc_pkg::SIZE_RESTART);
    end else begin
      size_ok = (sz >= lrc_pkg::SIZE_MIN);
    end
  endfunction

  // true on the last data byte; the size also counts the size and checksum bytes
  function automatic logic last_data(input logic [7:0] cnt, input logic [7:0] sz);
    last_data = (8'(cnt + 8'h03) == sz);
  endfunction

  // a size below the minimum leaves no room for an opcode
  function automatic logic too_short(input logic [7:0] sz);
    too_short = (sz < lrc_pkg::SIZE_MIN);
  endfunction

  // response code for a packet that was or was not received intact
  function automatic logic [7:0] resp_byte(input logic ok);
    resp_byte = ok ? lrc_pkg::BYTE_ACK : lrc_pkg::BYTE_NAK;
  endfunction

  // data bytes are stored only while they fit, so long packets cannot wrap onto the opcode
  assign mem_we = rx_valid_i && (r_reg.state == ST_DATA) && (r_reg.count < 8'(lrc_pkg::DEPTH));

  // raw data bytes kept for later commands
  lrc_mem #(
    .DEPTH(int'(lrc_pkg::DEPTH)),
    .AW(4)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .waddr_i(r_reg.count[3:0]),
    .wdata_i(rx_data_i),
    .raddr_i(lrc_pkg::IDX_OPCODE),
    .rdata_o(mem_rdata)
  );

  // next-state logic
  always_comb begin
    r_next = r_reg;
    // pulses last one cycle unless set again below
    r_next.run = 1'b0;
    r_next.other_cmd = 1'b0;
    unique case (r_reg.state)
      // wait for a size byte
      ST_IDLE: begin
        // zero bytes between packets are padding
        if (rx_valid_i && (rx_data_i != 8'h00)) begin
          r_next.size = rx_data_i;
          r_next.sum = 8'h00;
          r_next.count = 8'h00;
          r_next.state = ST_CSUM;
        end
      end
      // second byte is the checksum; a short size is refused at once
      ST_CSUM: begin
        if (rx_valid_i) begin
          r_next.csum = rx_data_i;
          if (too_short(r_reg.size)) begin
            r_next.good = 1'b0;
            r_next.state = ST_RESP;
          end else begin
            r_next.state = ST_DATA;
          end
        end
      end
      // data bytes: opcode first, then the address most significant byte first
      ST_DATA: begin
        if (rx_valid_i) begin
          // the sum wraps at eight bits, as the host's does
          r_next.sum = 8'(r_reg.sum + rx_data_i);
          if (r_reg.count == 8'h00) begin
            r_next.opcode = rx_data_i;
          end else if (r_reg.count <= 8'h04) begin
            r_next.addr = {r_reg.addr[23:0], rx_data_i};
          end
          r_next.count = 8'(r_reg.count + 8'h01);
          // judge the packet on its last byte, counting that byte in
          if (last_data(r_reg.count, r_reg.size)) begin
            r_next.good = (8'(r_reg.sum + rx_data_i) == r_reg.csum)
              && size_ok(r_next.opcode, r_reg.size);
            r_next.state = ST_RESP;
          end
        end
      end
      // offer the response and hold it until the host takes it
      ST_RESP: begin
        r_next.tx_valid = 1'b1;
        r_next.tx_data = resp_byte(r_reg.good);
        // taken when offered and ready meet at one edge
        if (r_reg.tx_valid && tx_ready_i) begin
          r_next.tx_valid = 1'b0;
          // acknowledge has been taken before any action
          r_next.state = r_reg.good ? ST_ACT : ST_IDLE;
        end
      end
      // the cycle after the response was taken: start the requested action
      ST_ACT: begin
        r_next.state = ST_IDLE;
        if (r_reg.opcode == lrc_pkg::OP_RUN) begin
          r_next.run = 1'b1;
          r_next.run_addr = r_reg.addr;
        end else if (r_reg.opcode == lrc_pkg::OP_RESTART) begin
          r_next.sys_reset = 1'b1;
          r_next.rst_cnt = lrc_pkg::RESET_PULSE_CYC;
          r_next.state = ST_RST;
        end else begin
          r_next.other_cmd = 1'b1;
          r_next.other_op = mem_rdata; // opcode stored at the first data byte
        end
      end
      // the pulse only reaches the system if sys_reset_o is wired to its reset
      ST_RST: begin
        // full reset held for a fixed pulse; the system reset then clears us
        if (r_reg.rst_cnt == 4'h1) begin
          r_next.sys_reset = 1'b0;
          r_next.state = ST_IDLE;
        end else begin
          r_next.rst_cnt = 4'(r_reg.rst_cnt - 4'h1);
        end
      end
      // an illegal one-hot code falls back to idle
      default: begin
        r_next.state = ST_IDLE;
      end
    endcase
  end

  // state register
  // synchronous reset: state starts at idle, addresses at their reset value, all else at zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r_reg <= '{state: ST_IDLE, run_addr: lrc_pkg::RESET_ADDR, addr: lrc_pkg::RESET_ADDR, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs come straight from the state register
  assign tx_valid_o = r_reg.tx_valid;
  assign tx_data_o = r_reg.tx_data;
  assign run_o = r_reg.run;
  assign run_addr_o = r_reg.run_addr;
  assign sys_reset_o = r_reg.sys_reset;
  assign other_cmd_o = r_reg.other_cmd;
  assign other_op_o = r_reg.other_op;
endmodule

// file: rtl/lrc_pkg.sv
// lrc_pkg: constants shared by the loader run/restart command block
// assumes: byte-wide serial link already deframed into byte strobes
package lrc_pkg;
  localparam logic [7:0] OP_RUN = 8'h22;
  localparam logic [7:0] OP_RESTART = 8'h25;
  localparam logic [7:0] OP_PING = 8'h20;
  localparam logic [7:0] BYTE_ACK = 8'hCC;
  localparam logic [7:0] BYTE_NAK = 8'h33;
  localparam logic [7:0] SIZE_RUN = 8'h07;
  localparam logic [7:0] SIZE_RESTART = 8'h03;
  localparam logic [7:0] SIZE_MIN = 8'h03;
  localparam logic [3:0] DEPTH = 4'hC; // most data bytes of one packet held
  localparam logic [3:0] IDX_OPCODE = 4'h0;
  localparam logic [31:0] RESET_ADDR = 32'h0000_0000;
  // time the reset request stays asserted
  localparam int RESET_PULSE_NS = 20;
  localparam int CLK_PERIOD_NS = 5;
  localparam logic [3:0] RESET_PULSE_CYC = 4'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage

// file: rtl/lrc_mem.sv
// lrc_mem: small byte memory holding the data bytes of one packet
// assumes: single clock, write and read ports independent, registered read
`timescale 1ns/100ps
module lrc_mem #(
  parameter int DEPTH = 12,
  parameter int AW = 4
) (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // read port
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [DEPTH];

  // write and registered read
  always_ff @(posedge clk_i) begin
    if (we_i && (32'(waddr_i) < DEPTH)) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= (32'(raddr_i) < DEPTH) ? mem[raddr_i] : 8'h00;
  end
endmodule

// file: testbench/lrc_chk.sv
// lrc_chk: port assertions for the loader run and restart block
// assumes: bound to lrc_top, one clock, synchronous active-low reset
`timescale 1ns/100ps
module lrc_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // response and actions
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic run_o,
  input wire logic sys_reset_o,
  input wire logic other_cmd_o
);
  logic ack_reg;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // reset request: four cycles high, then low
  sequence pulse_s;
    sys_reset_o [*4] ##1 !sys_reset_o;
  endsequence
  // response byte taken by the host, by its code
  sequence took_ack_s;
    tx_valid_o && tx_ready_i && tx_data_o == lrc_pkg::BYTE_ACK;
  endsequence
  sequence took_nak_s;
    tx_valid_o && tx_ready_i && tx_data_o == lrc_pkg::BYTE_NAK;
  endsequence
  // remembers the last response code taken until an action consumes it
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else if (tx_valid_o && tx_ready_i) begin
      ack_reg <= (tx_data_o == lrc_pkg::BYTE_ACK);
    end else if (run_o || sys_reset_o || other_cmd_o) begin
      ack_reg <= 1'b0;
    end
  end
  resp_code_a: assert property (tx_valid_o |-> tx_data_o == 8'hCC || tx_data_o == 8'h33)
    else $error("bad response code");
  resp_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("response dropped");
  run_after_ack_a: assert property ($rose(run_o) |-> ack_reg) else $error("run without ack");
  rst_after_ack_a: assert property ($rose(sys_reset_o) |-> ack_reg) else $error("reset without ack");
  rst_len_a: assert property ($rose(sys_reset_o) |-> pulse_s) else $error("reset pulse length");
  run_pulse_a: assert property (run_o |=> !run_o) else $error("run not a pulse");
  run_no_rst_a: assert property (run_o |-> !sys_reset_o ##1 !$rose(sys_reset_o))
    else $error("run caused reset");
  nak_quiet_a: assert property (took_nak_s |=> (!run_o && !sys_reset_o && !other_cmd_o) [*3])
    else $error("action after nak");
  ack_acts_a: assert property (took_ack_s |-> ##2 (run_o || sys_reset_o || other_cmd_o))
    else $error("no action after ack");
endmodule
bind lrc_top lrc_chk u_chk (.clk_i, .rst_n_i, .tx_valid_o, .tx_data_o, .tx_ready_i, .run_o, .sys_reset_o,
  .other_cmd_o);

// file: testbench/lrc_host.sv
// lrc_host: host side taking response bytes, promptly or after a stall
// assumes: shares the loader clock
`timescale 1ns/100ps
module lrc_host (
  // clock and mode
  input wire logic clk_i,
  input wire logic slow_i,
  // response handshake
  input wire logic valid_i,
  output logic ready_o
);
  logic [1:0] wait_reg;
  // take the byte at once or after three stalled cycles
  always_ff @(posedge clk_i) begin
    wait_reg <= (valid_i && !ready_o) ? wait_reg + 2'h1 : 2'h0;
    ready_o <= valid_i && !ready_o && (!slow_i || wait_reg == 2'h3);
  end
endmodule

// file: testbench/lrc_top_test.sv
// lrc_top_test: directed packets for the execute and restart commands
// assumes: lrc_top, lrc_host and lrc_chk compiled before
`timescale 1ns/100ps
module lrc_top_test;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rx_valid_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00;
  logic slow = 1'b0;
  logic tx_valid_o, tx_ready_i, run_o, sys_reset_o, other_cmd_o;
  logic [7:0] tx_data_o, other_op_o;
  logic [31:0] run_addr_o;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int runs, rsts, others;
  lrc_top u_dut (.clk_i, .rst_n_i, .rx_valid_i, .rx_data_i, .tx_valid_o, .tx_data_o, .tx_ready_i,
    .run_o, .run_addr_o, .sys_reset_o, .other_cmd_o, .other_op_o);
  lrc_host u_host (.clk_i, .slow_i(slow), .valid_i(tx_valid_o), .ready_o(tx_ready_i));
  // 200 MHz clock and hang guard
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // sends pad zeros, size, checksum (plus skew) and data, then watches 40 cycles
  task automatic pkt(input int pad, input logic [7:0] sz, input logic [7:0] skew, input logic [7:0] d[$],
    output logic [7:0] resp);
    logic [7:0] sum;
    logic [7:0] q[$];
    sum = skew;
    foreach (d[i]) sum += d[i];
    q = {sz, sum, d};
    resp = 8'h00;
    {runs, rsts, others} = '0;
    repeat (pad) q.push_front(8'h00);
    foreach (q[i]) begin
      @(posedge clk_i);
      rx_valid_i <= 1'b1;
      rx_data_i <= q[i];
    end
    @(posedge clk_i);
    rx_valid_i <= 1'b0;
    repeat (40) begin
      @(negedge clk_i);
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) resp = tx_data_o;
      runs += int'(run_o === 1'b1);
      rsts += int'(sys_reset_o === 1'b1);
      others += int'(other_cmd_o === 1'b1);
    end
  endtask
  task automatic run_cmd();
    logic [7:0] r;
    pkt(0, 8'h07, 8'h00, '{lrc_pkg::OP_RUN, 8'hA1, 8'hB2, 8'hC3, 8'hD4}, r);
    chk("run ack", r, lrc_pkg::BYTE_ACK);
    chk("run count", runs, 1);
    chk("run addr", run_addr_o, 32'hA1B2C3D4);
    chk("run reset", rsts, 0);
  endtask
  task automatic restart_cmd();
    logic [7:0] r;
    slow = 1'b1;
    pkt(2, 8'h03, 8'h00, '{lrc_pkg::OP_RESTART}, r);
    slow = 1'b0;
    chk("restart ack", r, lrc_pkg::BYTE_ACK);
    chk("reset cycles", rsts, 4);
    chk("restart run", runs, 0);
  endtask
  task automatic bad_cmds();
    logic [7:0] r;
    pkt(0, 8'h07, 8'h01, '{lrc_pkg::OP_RUN, 8'h00, 8'h00, 8'h10, 8'h00}, r);
    chk("bad sum nak", r, lrc_pkg::BYTE_NAK);
    chk("bad sum run", runs, 0);
    chk("bad sum addr", run_addr_o, 32'hA1B2C3D4);
    pkt(1, 8'h04, 8'h00, '{lrc_pkg::OP_RESTART, 8'h00}, r);
    chk("bad size nak", r, lrc_pkg::BYTE_NAK);
    chk("bad size reset", rsts, 0);
    pkt(0, 8'h03, 8'h00, '{lrc_pkg::OP_PING}, r);
    chk("ping ack", r, lrc_pkg::BYTE_ACK);
    chk("ping flag", others, 1);
    chk("ping opcode", other_op_o, lrc_pkg::OP_PING);
    pkt(0, 8'h02, 8'h00, '{8'h00}, r);
    chk("short nak", r, lrc_pkg::BYTE_NAK);
    chk("short action", runs + rsts + others, 0);
  endtask
  // reset, then each scenario in turn
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    run_cmd();
    bad_cmds();
    restart_cmd();
    conclude();
  end
endmodule
